// ==== hdl/acc_defines.svh ====
// Offsets, bit positions and reset values of the comparator control block
`ifndef ACC_DEFINES_SVH
`define ACC_DEFINES_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define ACC_OFF_CONV_CTRL_B   4'h0
`define ACC_OFF_COMP_CTRL     4'h4
`define ACC_OFF_DIG_IN_OFF    4'h8
// ****************************************
// Converter control B fields
// ****************************************
`define ACC_BIT_MUX_EN        6
`define ACC_TRIG_MSB          2
`define ACC_CCB_MASK          8'h47
`define ACC_CCB_RESET         8'h00
// ****************************************
// Comparator control and status fields
// ****************************************
`define ACC_BIT_DISABLE       7
`define ACC_BIT_BANDGAP       6
`define ACC_BIT_RESULT        5
`define ACC_BIT_FLAG          4
`define ACC_BIT_IRQ_EN        3
`define ACC_BIT_RESERVED      2
`define ACC_MODE_MSB          1
`define ACC_COMP_RESET        8'h00
// ****************************************
// Digital input disable fields
// ****************************************
`define ACC_BIT_NEG_OFF       1
`define ACC_BIT_POS_OFF       0
`define ACC_DID_MASK          8'h3F
`define ACC_DID_RESET         8'h00
// ****************************************
// Bus responses
// ****************************************
`define ACC_RESP_OKAY         2'h0
`define ACC_RESP_SLVERR       2'h2
`endif

// ==== hdl/acc_pkg.sv ====
// Types shared by the comparator control block
package acc_pkg;
  // ****************************************
  // Interrupt trigger modes
  // ****************************************
  typedef enum logic [1:0] {
    ACC_MODE_TOGGLE = 2'h0,
    ACC_MODE_RESV   = 2'h1,
    ACC_MODE_FALL   = 2'h2,
    ACC_MODE_RISE   = 2'h3
  } acc_mode_e;
  // ****************************************
  // Register select from address decode
  // ****************************************
  typedef enum logic [1:0] {
    ACC_SEL_CCB  = 2'h0,
    ACC_SEL_COMP = 2'h1,
    ACC_SEL_DID  = 2'h2,
    ACC_SEL_NONE = 2'h3
  } acc_sel_e;
  // ****************************************
  // Controls toward the analog core
  // ****************************************
  typedef struct packed {
    logic       comparator_disable;
    logic       bandgap_select;
    logic       negative_mux_active;
    logic [1:0] channel_select;
  } acc_analog_ctrl_s;
endpackage

// ==== hdl/acc_top.sv ====
// Comparator control, event detection and AXI4-Lite register slave
`timescale 1ns/10ps
`include "acc_defines.svh"
module acc_top
  import acc_pkg::*;
#(
  parameter int ADDR_W = 4
) (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  // AXI4-Lite write data
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp_o,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  // AXI4-Lite read data
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  // Analog side and neighbours
  input  wire logic              comp_raw_i,
  input  wire logic [1:0]        pin_level_i,
  input  wire logic              converter_enable_i,
  input  wire logic [1:0]        channel_select_i,
  input  wire logic              global_irq_enable_i,
  input  wire logic              irq_vector_ack_i,
  output acc_analog_ctrl_s       analog_ctrl_o,
  output logic [2:0]             trigger_select_o,
  output logic [5:0]             input_off_o,
  output logic [1:0]             pin_read_o,
  output logic                   irq_o
);

  // ****************************************
  // Declarations
  // ****************************************
  logic [7:0]        conv_ctrl_b;     // Converter control B
  logic              comp_disable;    // Comparator power off
  logic              bandgap_sel;     // Positive input from reference
  logic              irq_enable;      // Comparator interrupt enable
  acc_mode_e         irq_mode;        // Trigger mode
  logic              irq_flag;        // Sticky comparator event
  logic [7:0]        dig_in_off;      // Digital input disables
  logic              comp_meta;       // Synchroniser first stage
  logic              comp_result;     // Synchronised result
  logic              comp_prev;       // Result one cycle earlier
  logic [1:0]        pin_meta;        // Pin sync first stage
  logic [1:0]        pin_sync;        // Pin sync second stage
  logic              set_event;       // Selected event this cycle
  logic              aw_held;         // Write address captured
  logic              w_held;          // Write data captured
  logic [3:0]        aw_addr;         // Captured write address
  logic [31:0]       w_data;          // Captured write data
  logic [3:0]        w_strb;          // Captured strobes
  logic              wr_fire;         // Write performed this cycle
  logic              wr_lane0;        // Write reaches low byte
  acc_sel_e          wr_sel;          // Decoded write target
  acc_sel_e          rd_sel;          // Decoded read target
  logic [7:0]        comp_status;     // Read view of control/status
  logic [7:0]        rd_byte;         // Selected read byte
  logic              flag_w1c;        // Software writes one to flag

  // ****************************************
  // Helper functions
  // ****************************************
  // Address decode, shared by both channels
  function automatic acc_sel_e acc_decode(input logic [3:0] addr);
    case (addr)
      `ACC_OFF_CONV_CTRL_B: acc_decode = ACC_SEL_CCB;
      `ACC_OFF_COMP_CTRL:   acc_decode = ACC_SEL_COMP;
      `ACC_OFF_DIG_IN_OFF:  acc_decode = ACC_SEL_DID;
      default:              acc_decode = ACC_SEL_NONE;
    endcase
  endfunction

  // ****************************************
  // Comparator synchroniser
  // ****************************************
  // Two-stage result sync
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      comp_meta   <= 1'b0;
      comp_result <= 1'b0;
    end else begin
      comp_meta   <= comp_raw_i;
      comp_result <= comp_meta;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      comp_prev <= 1'b0;
    end else begin
      comp_prev <= comp_result;
    end
  end

  // ****************************************
  // Event selection
  // ****************************************
  // Reserved mode is kept out so stray settings stay quiet
  always_comb begin
    case (irq_mode)
      ACC_MODE_TOGGLE: set_event = comp_result ^ comp_prev;
      ACC_MODE_FALL:   set_event = comp_prev & ~comp_result;
      ACC_MODE_RISE:   set_event = comp_result & ~comp_prev;
      default:         set_event = 1'b0;
    endcase
  end

  // ****************************************
  // Register bus: write side
  // ****************************************
  // Ready drops while a captured item or a response is pending
  assign s_axi_awready_o = ~aw_held & ~s_axi_bvalid_o;
  assign s_axi_wready_o  = ~w_held & ~s_axi_bvalid_o;
  assign wr_fire  = aw_held & w_held & ~s_axi_bvalid_o;
  assign wr_sel   = acc_decode(aw_addr);
  assign wr_lane0 = wr_fire & w_strb[0];

  // Address capture, independent of data
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      aw_held <= 1'b0;
      aw_addr <= 4'h0;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_held <= 1'b1;
      aw_addr <= 4'(s_axi_awaddr_i);
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  // Data capture, independent of address
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata_i;
      w_strb <= s_axi_wstrb_i;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  // Write response; unmapped offsets answer with an error
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= `ACC_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o  <= (wr_sel == ACC_SEL_NONE) ?
                        `ACC_RESP_SLVERR : `ACC_RESP_OKAY;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  // Mux enable and trigger field
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      conv_ctrl_b <= `ACC_CCB_RESET;
    end else if (wr_lane0 && wr_sel == ACC_SEL_CCB) begin
      conv_ctrl_b <= w_data[7:0] & `ACC_CCB_MASK;
    end
  end

  // Comparator control fields; enable and mode ordering is up
  // to software, the logic does not police it
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      comp_disable <= 1'(`ACC_COMP_RESET >> `ACC_BIT_DISABLE);
      bandgap_sel  <= 1'b0;
      irq_enable   <= 1'b0;
      irq_mode     <= ACC_MODE_TOGGLE;
    end else if (wr_lane0 && wr_sel == ACC_SEL_COMP) begin
      comp_disable <= w_data[`ACC_BIT_DISABLE];
      bandgap_sel  <= w_data[`ACC_BIT_BANDGAP];
      irq_enable   <= w_data[`ACC_BIT_IRQ_EN];
      irq_mode     <= acc_mode_e'(w_data[`ACC_MODE_MSB:0]);
    end
  end

  // Digital input disable register
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dig_in_off <= `ACC_DID_RESET;
    end else if (wr_lane0 && wr_sel == ACC_SEL_DID) begin
      dig_in_off <= w_data[7:0] & `ACC_DID_MASK;
    end
  end

  // ****************************************
  // Interrupt flag
  // ****************************************
  assign flag_w1c = wr_lane0 && wr_sel == ACC_SEL_COMP &&
                    w_data[`ACC_BIT_FLAG];

  // A new event wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      irq_flag <= 1'b0;
    end else if (set_event) begin
      irq_flag <= 1'b1;
    end else if (irq_vector_ack_i || flag_w1c) begin
      irq_flag <= 1'b0;
    end
  end

  assign irq_o = irq_flag & irq_enable & global_irq_enable_i;

  // ****************************************
  // Register bus: read side
  // ****************************************
  assign s_axi_arready_o = ~s_axi_rvalid_o;
  assign rd_sel          = acc_decode(4'(s_axi_araddr_i));

  always_comb begin
    comp_status = 8'h00;
    comp_status[`ACC_BIT_DISABLE] = comp_disable;
    comp_status[`ACC_BIT_BANDGAP] = bandgap_sel;
    comp_status[`ACC_BIT_RESULT]  = comp_result;
    comp_status[`ACC_BIT_FLAG]    = irq_flag;
    comp_status[`ACC_BIT_IRQ_EN]  = irq_enable;
    comp_status[`ACC_MODE_MSB:0]  = irq_mode;
  end

  // Read multiplexer
  always_comb begin
    case (rd_sel)
      ACC_SEL_CCB:  rd_byte = conv_ctrl_b;
      ACC_SEL_COMP: rd_byte = comp_status;
      ACC_SEL_DID:  rd_byte = dig_in_off;
      default:      rd_byte = 8'h00;
    endcase
  end

  // Read data held until the master takes it
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= 32'h0000_0000;
      s_axi_rresp_o  <= `ACC_RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o  <= {24'h00_0000, rd_byte};
      s_axi_rresp_o  <= (rd_sel == ACC_SEL_NONE) ?
                        `ACC_RESP_SLVERR : `ACC_RESP_OKAY;
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // ****************************************
  // Analog controls and pin reads
  // ****************************************
  // Bandgap routing
  assign analog_ctrl_o.bandgap_select     = bandgap_sel;
  assign analog_ctrl_o.comparator_disable = comp_disable;
  assign analog_ctrl_o.negative_mux_active =
    conv_ctrl_b[`ACC_BIT_MUX_EN] & ~converter_enable_i;
  assign analog_ctrl_o.channel_select =
    analog_ctrl_o.negative_mux_active ? channel_select_i : 2'h0;
  assign trigger_select_o = conv_ctrl_b[`ACC_TRIG_MSB:0];
  assign input_off_o      = dig_in_off[5:0];

  // Pin levels are asynchronous, so two stages first
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pin_meta <= 2'h0;
      pin_sync <= 2'h0;
    end else begin
      pin_meta <= pin_level_i;
      pin_sync <= pin_meta;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pin_read_o <= 2'h0;
    end else begin
      pin_read_o <= pin_sync & ~dig_in_off[`ACC_BIT_NEG_OFF:0];
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_rise;
    !comp_prev ##0 comp_result;
  endsequence

  sequence s_fall;
    comp_prev ##0 !comp_result;
  endsequence

  property p_sync;
    @(posedge clk_i) disable iff (!rst_n_i)
      $past(rst_n_i, 2) && $past(rst_n_i)
      |-> comp_result == $past(comp_raw_i, 2);
  endproperty
  a_sync: assert property (p_sync)
    else $error("Result does not follow raw input");

  property p_rise;
    @(posedge clk_i) disable iff (!rst_n_i)
      (irq_mode == ACC_MODE_RISE) ##0 s_rise |=> irq_flag;
  endproperty
  a_rise: assert property (p_rise)
    else $error("Rising edge did not set flag");

  property p_fall;
    @(posedge clk_i) disable iff (!rst_n_i)
      (irq_mode == ACC_MODE_FALL) ##0 s_fall |=> irq_flag;
  endproperty
  a_fall: assert property (p_fall)
    else $error("Falling edge did not set flag");

  property p_resv;
    @(posedge clk_i) disable iff (!rst_n_i)
      $rose(irq_flag) |-> $past(irq_mode) != ACC_MODE_RESV;
  endproperty
  a_resv: assert property (p_resv)
    else $error("Reserved mode set the flag");

  property p_clear;
    @(posedge clk_i) disable iff (!rst_n_i)
      irq_vector_ack_i && !set_event |=> !irq_flag;
  endproperty
  a_clear: assert property (p_clear)
    else $error("Vector did not clear flag");

  property p_irq;
    @(posedge clk_i) disable iff (!rst_n_i)
      irq_o |-> irq_flag && irq_enable && global_irq_enable_i;
  endproperty
  a_irq: assert property (p_irq)
    else $error("Request without all enables");

  property p_rsvd_read;
    @(posedge clk_i) disable iff (!rst_n_i)
      s_axi_arvalid_i && s_axi_arready_o && rd_sel == ACC_SEL_COMP
      |=> s_axi_rdata_o[`ACC_BIT_RESERVED] == 1'b0 &&
          s_axi_rdata_o[`ACC_BIT_RESULT] == $past(comp_result);
  endproperty
  a_rsvd_read: assert property (p_rsvd_read)
    else $error("Status read view wrong");

  property p_mux;
    @(posedge clk_i) disable iff (!rst_n_i)
      converter_enable_i |-> !analog_ctrl_o.negative_mux_active;
  endproperty
  a_mux: assert property (p_mux)
    else $error("Mux active while converter on");

  property p_pin;
    @(posedge clk_i) disable iff (!rst_n_i)
      dig_in_off[`ACC_BIT_POS_OFF] ##1 dig_in_off[`ACC_BIT_POS_OFF]
      |-> pin_read_o[0] == 1'b0;
  endproperty
  a_pin: assert property (p_pin)
    else $error("Disabled pin read not zero");

  property p_disable;
    @(posedge clk_i) disable iff (!rst_n_i)
      wr_lane0 && wr_sel == ACC_SEL_COMP
      |=> analog_ctrl_o.comparator_disable ==
          $past(w_data[`ACC_BIT_DISABLE]);
  endproperty
  a_disable: assert property (p_disable)
    else $error("Disable bit not taken");

endmodule // acc_top

// ==== verification/acc_analog_model.sv ====
// Behavioural model of the analog comparator core and its input mux
`timescale 1ns/10ps
module acc_analog_model
  import acc_pkg::*;
#(
  parameter logic [7:0] BANDGAP_LEVEL = 8'h80  // Plain default level
) (
  input  wire acc_analog_ctrl_s ctrl_i,        // Controls from the block
  input  wire logic [7:0]       pos_level_i,   // Positive pin level
  input  wire logic [7:0]       neg_level_i,   // Negative pin level
  input  wire logic [31:0]      chan_level_i,  // Four channel levels
  output logic                  comp_raw_o     // Raw comparison result
);
  // ****************************************
  // Input selection
  // ****************************************
  logic [7:0] pos_sel;  // Level seen at the positive input
  logic [7:0] neg_sel;  // Level seen at the negative input
  assign pos_sel = ctrl_i.bandgap_select ? BANDGAP_LEVEL : pos_level_i;
  assign neg_sel = ctrl_i.negative_mux_active ?
                   chan_level_i[ctrl_i.channel_select*8 +: 8] : neg_level_i;
  // powered-off core reads low, else compares
  // An unpowered core gives no valid answer; low is the simplest stand-in
  assign comp_raw_o = !ctrl_i.comparator_disable && (pos_sel > neg_sel);
endmodule  // acc_analog_model

// ==== verification/analog_comparator_control_test.sv ====
// Self-checking bench for the comparator control block
`timescale 1ns/10ps
`include "acc_defines.svh"
module analog_comparator_control_test
  import acc_pkg::*;
();
  // ****************************************
  // Signals
  // ****************************************
  localparam logic [3:0] CCB = `ACC_OFF_CONV_CTRL_B;  // Converter ctrl B
  localparam logic [3:0] CMP = `ACC_OFF_COMP_CTRL;    // Comparator ctrl
  localparam logic [3:0] DID = `ACC_OFF_DIG_IN_OFF;   // Input disable
  logic clk_i, rst_n_i;
  logic [3:0] s_axi_awaddr_i, s_axi_araddr_i, s_axi_wstrb_i;
  logic s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o, rd;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rsp, pin_level_i, pin_read_o;
  logic s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o;
  logic s_axi_rvalid_o, s_axi_rready_i, comp_raw_i, converter_enable_i;
  logic [1:0] channel_select_i;
  logic global_irq_enable_i, irq_vector_ack_i, irq_o;
  acc_analog_ctrl_s analog_ctrl_o;  // Controls toward the core
  logic [2:0]  trigger_select_o;    // Stored trigger field
  logic [5:0]  input_off_o;         // Stored input-off bits
  logic [7:0]  v_pos, v_neg, m;     // Pin levels, mode index
  logic [31:0] v_ch;                // Channel levels, channel 0 lowest
  int          err_total, n_tests;  // Report counters
  // ****************************************
  // Design, partner and clock
  // ****************************************
  acc_top uut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_awvalid_i(s_axi_awvalid_i),
    .s_axi_awready_o(s_axi_awready_o), .s_axi_wdata_i(s_axi_wdata_i),
    .s_axi_wstrb_i(s_axi_wstrb_i), .s_axi_wvalid_i(s_axi_wvalid_i),
    .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
    .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
    .s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
    .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
    .s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
    .s_axi_rready_i(s_axi_rready_i), .comp_raw_i(comp_raw_i),
    .pin_level_i(pin_level_i), .converter_enable_i(converter_enable_i),
    .channel_select_i(channel_select_i), .irq_o(irq_o),
    .global_irq_enable_i(global_irq_enable_i),
    .irq_vector_ack_i(irq_vector_ack_i), .analog_ctrl_o(analog_ctrl_o),
    .trigger_select_o(trigger_select_o), .input_off_o(input_off_o),
    .pin_read_o(pin_read_o));
  acc_analog_model model (.ctrl_i(analog_ctrl_o), .pos_level_i(v_pos),
    .neg_level_i(v_neg), .chan_level_i(v_ch), .comp_raw_o(comp_raw_i));
  // 100 ns period
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // ****************************************
  // Tasks
  // ****************************************
  // Ends the run with counts and verdict
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Counts a used-up wait as a mismatch
  task automatic hang();
    err_total++;
    $display("mismatch at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    wrap_up();
  endtask
  // One comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
  endtask
  // Write: AW and W offered together, each dropped once taken
  task automatic axi_wr(input logic [3:0] a, input logic [7:0] d,
                        input logic [3:0] s, output logic [1:0] r);
    logic aw_p, w_p;
    int   n;
    aw_p = 1'b1;
    w_p  = 1'b1;
    s_axi_awaddr_i  <= a;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wdata_i   <= {24'h0, d};
    s_axi_wstrb_i   <= s;
    s_axi_wvalid_i  <= 1'b1;
    s_axi_bready_i  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_i);
      if (s_axi_bvalid_o === 1'b1) break;
      if (aw_p && s_axi_awready_o === 1'b1) begin
        aw_p = 1'b0;
        s_axi_awvalid_i <= 1'b0;
      end
      if (w_p && s_axi_wready_o === 1'b1) begin
        w_p = 1'b0;
        s_axi_wvalid_i <= 1'b0;
      end
    end
    if (n == 50) hang();
    r = s_axi_bresp_o;
    s_axi_bready_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // Read: AR dropped once taken, data taken with rvalid
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    logic ar_p;
    int   n;
    ar_p = 1'b1;
    s_axi_araddr_i  <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_i);
      if (s_axi_rvalid_o === 1'b1) break;
      if (ar_p && s_axi_arready_o === 1'b1) begin
        ar_p = 1'b0;
        s_axi_arvalid_i <= 1'b0;
      end
    end
    if (n == 50) hang();
    d = s_axi_rdata_o;
    r = s_axi_rresp_o;
    s_axi_rready_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    axi_wr(a, d, 4'hF, rsp);
    chk({30'h0, rsp}, 32'h0);
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] e);
    axi_rd(a, rd, rsp);
    chk(rd, {24'h0, e});
    chk({30'h0, rsp}, 32'h0);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {rst_n_i, s_axi_awaddr_i, s_axi_araddr_i, s_axi_wstrb_i} = '0;
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = '0;
    {s_axi_arvalid_i, s_axi_rready_i, s_axi_wdata_i} = '0;
    {pin_level_i, converter_enable_i, channel_select_i} = '0;
    {global_irq_enable_i, irq_vector_ack_i, err_total, n_tests} = '0;
    v_pos = 8'h20;
    v_neg = 8'h40;
    v_ch  = 32'hF010F0F0;
    tick(8);
    rst_n_i <= 1'b1;
    tick(1);
    rc(CCB, 8'h00);
    rc(CMP, 8'h00);
    rc(DID, 8'h00);
    wr(CCB, 8'hFF);
    rc(CCB, 8'h47);
    chk({29'h0, trigger_select_o}, 32'h7);
    // Unmapped place and a write with its byte lane off
    axi_wr(4'hC, 8'hFF, 4'hF, rsp);
    chk({30'h0, rsp}, 32'h2);
    axi_rd(4'hC, rd, rsp);
    chk(rd, 32'h0);
    chk({30'h0, rsp}, 32'h2);
    axi_wr(DID, 8'h03, 4'h0, rsp);
    rc(DID, 8'h00);
    // Pin read gating
    pin_level_i <= 2'b11;
    tick(4);
    chk({30'h0, pin_read_o}, 32'h3);
    wr(DID, 8'hFF);
    rc(DID, 8'h3F);
    chk({26'h0, input_off_o}, 32'h3F);
    chk({30'h0, pin_read_o}, 32'h0);
    wr(DID, 8'h01);
    chk({30'h0, pin_read_o}, 32'h2);
    // Channel 2 replaces the negative pin while the converter is off
    wr(CCB, 8'h40);
    channel_select_i <= 2'h2;
    tick(5);
    chk({27'h0, analog_ctrl_o}, 32'h06);
    rc(CMP, 8'h30);
    converter_enable_i <= 1'b1;
    tick(5);
    chk({27'h0, analog_ctrl_o}, 32'h00);
    rc(CMP, 8'h10);
    converter_enable_i <= 1'b0;
    wr(CCB, 8'h00);
    // Every mode against a rise and a fall, enable kept clear
    for (m = 8'h0; m < 8'h4; m++) begin
      wr(CMP, 8'h10 | m);
      v_pos <= 8'h60;
      tick(5);
      rc(CMP, 8'h20 | ((m == 0 || m == 3) ? 8'h10 : 8'h00) | m);
      wr(CMP, 8'h10 | m);
      v_pos <= 8'h20;
      tick(5);
      rc(CMP, ((m == 0 || m == 2) ? 8'h10 : 8'h00) | m);
    end
    // Request gating and flag clearing
    wr(CMP, 8'h10);
    v_pos <= 8'h60;
    tick(5);
    wr(CMP, 8'h08);
    rc(CMP, 8'h38);
    global_irq_enable_i <= 1'b1;
    tick(1);
    chk({31'h0, irq_o}, 32'h1);
    global_irq_enable_i <= 1'b0;
    tick(1);
    chk({31'h0, irq_o}, 32'h0);
    global_irq_enable_i <= 1'b1;
    wr(CMP, 8'h00);
    chk({31'h0, irq_o}, 32'h0);
    wr(CMP, 8'h08);
    chk({31'h0, irq_o}, 32'h1);
    irq_vector_ack_i <= 1'b1;
    tick(1);
    irq_vector_ack_i <= 1'b0;
    tick(1);
    chk({31'h0, irq_o}, 32'h0);
    rc(CMP, 8'h28);
    // Power off and bandgap, enable cleared first
    wr(CMP, 8'h00);
    wr(CMP, 8'h81);
    tick(5);
    rc(CMP, 8'h81);
    chk({31'h0, analog_ctrl_o.comparator_disable}, 32'h1);
    v_pos <= 8'h20;
    wr(CMP, 8'h41);
    tick(5);
    rc(CMP, 8'h61);
    chk({27'h0, analog_ctrl_o}, 32'h08);
    wrap_up();
  end
  // Watchdog against a hang
  initial begin
    tick(20000);
    hang();
  end
endmodule  // analog_comparator_control_test
